// File: core/align_fifo.sv
/*
 One link's alignment store: 24 words of byte, frame marker and parity.
 Assumes write and read sides share the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module align_fifo
   import rx_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Write side
   input  wire logic [4:0] wr_addr,
   input  wire fifo_word_t wr_word,
   // Read side, word shows one cycle after rd_en
   input  wire logic       rd_en,
   input  wire logic [4:0] rd_addr,
   output      fifo_word_t rd_word
);
   fifo_st_t s;
   fifo_st_t n;

   always_comb begin
      n = s;
      n.mem[wr_addr] = wr_word;
      if (rd_en) begin
         n.rd = s.mem[rd_addr];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign rd_word = s.rd;
endmodule // align_fifo
`default_nettype wire

// File: core/rx_params.svh
/*
 Constants of the receive alignment and pointer mover path: offsets, field
 positions, reset values and timing counts. Assumes a 10 MHz system clock.
*/
// Contract
// - Per-link 24x10 FIFO absorbs interlink skew.
// - Frame pulses over 19 clocks apart flag error.
// - Auto sync once; later only by resync.
// - Counter from 24, minus one, then two.
// - Frame marker rides byte before first A1.
// - First A1 always lands at address 0.
// - Aligned reads start together at address 0.
// - Depth above 12 raises alignment overflow.
// - Disabled links ignored; enabling disturbs nobody.
// - Concatenations start on STS-3 boundaries.
// - Single differing valid pointer is ignored (code accepts one just after an increment or decrement).
// - Two normal pointers enter normal state.
// - Increment, decrement use eight-of-ten vote.
// - Concatenation state follows the chain head.
// - Two AIS pointers enter AIS state.
// - J1 mismatch or AIS exit flags new data.
// - Adjustments latched at F1 or E2 slot.
// - Every adjustment passed on without rate limit.
// - AIS forces 0xFF until state exits and J1.
// - K1, K2 and SS bits passed through.
`ifndef RX_PARAMS_SVH
`define RX_PARAMS_SVH
`define LINKS        4
`define FIFO_DEPTH   24
`define ADDR_LAST    5'h17
`define WR_PRE       5'h17
`define ALIGN_START  6'h18
`define SPREAD_MAX   5'h12
`define DEPTH_MAX    5'h0C
`define DEPTH_WRAP   5'h18
`define CLK_PS       100000
`define SKEW_PS      154300
`define SKEW_CYC     ((`SKEW_PS / `CLK_PS) < 1 ? 1 : (`SKEW_PS / `CLK_PS))
`define COL_LAST     11'h437
`define ROW_LAST     4'h8
`define TOH_COLS     11'h024
`define STS_N        11'h00C
`define H_ROW        4'h3
`define H2_COL       11'h00C
`define K_ROW        4'h4
`define K1_COL       11'h00C
`define K2_COL       11'h018
`define F1_ROW       4'h1
`define E2_ROW       4'h8
`define LATCH_COL    11'h018
`define PTR_MAX      10'h30E
`define AIS_BYTE     8'hFF
`define AIS_PTR      16'hFFFF
`define NDF_NORMAL_POINTER_STATE     4'h6
`define NDF_CONCATENATION_POINTER_STATE     4'h9
`define CONCATENATION_POINTER_STATE_VAL     10'h3FF
`define INC_MASK     10'h2AA
`define DEC_MASK     10'h155
`define VOTE_MIN     4'h8
`define NDF_VOTE     3'h3
`endif

// File: core/rx_pkg.sv
/*
 Types of the receive alignment and pointer mover path.
 Assumes rx_params.svh is on the include path.
*/
`include "rx_params.svh"
package rx_pkg;
   typedef enum logic [1:0] {normal_pointer_state, ais_pointer_state, concatenation_pointer_state} ptr_state_t;
   typedef enum logic [1:0] {cls_invalid, cls_normal_pointer_state, cls_concatenation_pointer_state, cls_ais} ptr_cls_t;

   typedef struct packed {
      logic       par;
      logic       frame;
      logic [7:0] data;
   } fifo_word_t;

   typedef struct packed {
      logic [7:0] data;
      logic       frame;
      logic       new_data_flag_indication;
      logic       inc;
      logic       dec;
   } out_word_t;

   typedef struct packed {
      ptr_state_t  st;
      ptr_cls_t    cls_prev;
      logic [9:0]  val_prev;
      logic [9:0]  off;
      logic [9:0]  goff;
      logic [7:0]  h1;
      logic [10:0] col;
      logic [3:0]  row;
      logic [9:0]  spe;
      logic        inc_req;
      logic        dec_req;
      logic        slot_e2;
      logic        slot_set;
      logic        ais_out;
      logic        ndf_flag;
      logic        inc_flag;
      logic        dec_flag;
      logic [7:0]  k1;
      logic [7:0]  k2;
      logic [1:0]  ss;
   } ptr_t;

   typedef struct packed {
      fifo_word_t [`FIFO_DEPTH-1:0] mem;
      fifo_word_t                   rd;
   } fifo_st_t;

   typedef struct packed {
      out_word_t e0;
      out_word_t e1;
      logic      v0;
      logic      v1;
   } buf_st_t;

   typedef struct packed {
      logic [3:0][4:0] wa;
      logic [3:0]      fpd;
      logic [3:0]      armed;
      logic [3:0]      seen;
      logic            active;
      logic [5:0]      cnt;
      logic [4:0]      spread;
      logic            err;
      logic [3:0]      run;
      logic [3:0][4:0] ra;
      logic [3:0]      rvld;
      logic [3:0]      ovf;
      logic [10:0]     scol;
      logic [3:0]      srow;
      ptr_t [3:0]      pm;
   } top_st_t;
endpackage

// File: core/skid_buf.sv
/*
 Two-entry buffer between the pointer mover and the fabric.
 Assumes the source holds its word while in_ready is low.
*/
`timescale 1ns/10ps
`default_nettype none
module skid_buf
   import rx_pkg::*;
(
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      rst_n,
   // Filling side
   input  wire logic      in_valid,
   output      logic      in_ready,
   input  wire out_word_t in_data,
   // Draining side
   output      logic      out_valid,
   input  wire logic      out_ready,
   output      out_word_t out_data
);
   buf_st_t s;
   buf_st_t n;

   always_comb begin
      n = s;
      if (s.v0 && out_ready) begin
         n.e0 = s.e1;
         n.v0 = s.v1;
         n.v1 = 1'b0;
      end
      // Ready only depends on the second slot, so it is a plain flop
      if (in_valid && !s.v1) begin
         if (!n.v0) begin
            n.e0 = in_data;
            n.v0 = 1'b1;
         end else begin
            n.e1 = in_data;
            n.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign in_ready  = !s.v1;
   assign out_valid = s.v0;
   assign out_data  = s.e0;
endmodule // skid_buf
`default_nettype wire

// File: core/sts12_rx_align_pointer_mover.sv
/*
 Receive path of four byte links: write control, alignment sync, read control,
 depth watch and a per-link pointer interpreter and generator.
 Assumes link bytes and frame pulses arrive on clk, one byte per clock,
 and that the pointer interpreter follows STS-1 number one of each link.
*/
`timescale 1ns/10ps
`default_nettype none
module sts12_rx_align_pointer_mover
   import rx_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Links from the descrambler
   input  wire logic [3:0][7:0] lk_data,
   input  wire logic [3:0]      lk_fp,
   // System frame and control
   input  wire logic            sys_fp,
   input  wire logic [3:0]      link_enable,
   input  wire logic [3:0]      resync,
   // Data to the fabric
   output      logic [3:0]      out_valid,
   input  wire logic [3:0]      out_ready,
   output      out_word_t [3:0] out_data,
   // Status
   output      logic            align_err,
   output      logic [3:0]      align_ovf,
   output      ptr_state_t [3:0] ptr_state,
   output      logic [3:0][7:0] k1_byte,
   output      logic [3:0][7:0] k2_byte,
   output      logic [3:0][1:0] ss_bits
);
   top_st_t         s;
   top_st_t         n;
   fifo_word_t [3:0] fifo_rd;
   fifo_word_t [3:0] fifo_wr;
   logic [3:0]      rd_en;
   logic [3:0]      buf_ready;
   out_word_t [3:0] buf_in;
   logic [3:0]      acc;
   logic [3:0]      pulses;
   logic [3:0]      part;
   logic [3:0]      seen_n;
   logic            all_in;
   logic            start;
   logic [5:0]      step;
   logic [5:0]      base;
   logic [4:0]      spread_n;
   logic [4:0]      depth;
   ptr_t            p;
   ptr_state_t      st_old;
   fifo_word_t      w;
   logic [15:0]     hp;
   ptr_cls_t        cls;
   logic            incd;
   logic            decd;
   logic            pay1;
   logic [9:0]      idx;
   logic            cf1;
   logic            ce2;

   function automatic logic [3:0] ones10(input logic [9:0] v);
      logic [3:0] c;
      c = 4'h0;
      for (int b = 0; b < 10; b++) begin
         c = c + {3'h0, v[b]};
      end
      return c;
   endfunction

   // Flag nibble accepted with at most one bit wrong
   function automatic logic nib_ok(input logic [3:0] v, input logic [3:0] pat);
      logic [3:0] m;
      m = ~(v ^ pat);
      return ({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]}) >= `NDF_VOTE;
   endfunction

   function automatic logic [4:0] addr_inc(input logic [4:0] a);
      return (a == `ADDR_LAST) ? 5'h00 : a + 5'h01;
   endfunction

   function automatic logic [9:0] off_step(input logic [9:0] o, input logic up);
      if (up) begin
         return (o == `PTR_MAX) ? 10'h000 : o + 10'h001;
      end
      return (o == 10'h000) ? `PTR_MAX : o - 10'h001;
   endfunction

   genvar g;
   generate
      for (g = 0; g < `LINKS; g++) begin : g_link
         align_fifo u_fifo (
            .clk     (clk),
            .rst_n   (rst_n),
            .wr_addr (s.wa[g]),
            .wr_word (fifo_wr[g]),
            .rd_en   (rd_en[g]),
            .rd_addr (s.ra[g]),
            .rd_word (fifo_rd[g])
         );
         skid_buf u_buf (
            .clk       (clk),
            .rst_n     (rst_n),
            .in_valid  (s.rvld[g]),
            .in_ready  (buf_ready[g]),
            .in_data   (buf_in[g]),
            .out_valid (out_valid[g]),
            .out_ready (out_ready[g]),
            .out_data  (out_data[g])
         );
         // Marker rides with the byte written just before the first A1
         assign fifo_wr[g] = '{par: ^lk_data[g], frame: s.fpd[g], data: lk_data[g]};
      end
   endgenerate

   always_comb begin
      n = s;
      n.fpd = lk_fp;
      rd_en = 4'h0;
      acc = 4'h0;
      buf_in = '0;
      p = '0;
      st_old = normal_pointer_state;
      w = '0;
      hp = 16'h0000;
      cls = cls_invalid;
      incd = 1'b0;
      decd = 1'b0;
      pay1 = 1'b0;
      idx = 10'h000;
      cf1 = 1'b0;
      ce2 = 1'b0;
      depth = 5'h00;
      // Only armed, enabled links take part in a sync
      part = s.armed & link_enable;
      pulses = lk_fp & part;
      seen_n = (s.active ? s.seen : 4'h0) | pulses;
      all_in = (seen_n & part) == part;
      step = all_in ? 6'h02 : 6'h01;
      base = s.active ? s.cnt : `ALIGN_START;
      spread_n = s.active ? s.spread + 5'h01 : 5'h00;
      start = 1'b0;
      n.err = 1'b0;
      if (s.active || (|pulses)) begin
         n.active = 1'b1;
         n.seen = seen_n;
         n.cnt = base - step;
         n.spread = spread_n;
         if (!all_in && spread_n > `SPREAD_MAX) begin
            // Links stay armed and try again at the next frame pulse of any of them
            n.err = 1'b1;
            n.active = 1'b0;
            n.seen = 4'h0;
         end else if (base <= step) begin
            start = 1'b1;
            n.active = 1'b0;
            n.seen = 4'h0;
         end
      end
      if (sys_fp) begin
         n.scol = 11'h000;
         n.srow = 4'h0;
      end else if (s.scol == `COL_LAST) begin
         n.scol = 11'h000;
         n.srow = (s.srow == `ROW_LAST) ? 4'h0 : s.srow + 4'h1;
      end else begin
         n.scol = s.scol + 11'h001;
      end

      for (int i = 0; i < `LINKS; i++) begin
         // Frame pulse is two bytes ahead of A1, so A1 lands on address 0
         n.wa[i] = lk_fp[i] ? `WR_PRE : addr_inc(s.wa[i]);
         if (start && seen_n[i]) begin
            n.run[i] = 1'b1;
            n.ra[i] = 5'h00;
            n.armed[i] = 1'b0;
         end
         // A stalled fabric holds reads; the depth watch then reports it
         rd_en[i] = s.run[i] && buf_ready[i];
         if (rd_en[i]) begin
            n.ra[i] = addr_inc(s.ra[i]);
         end
         acc[i] = s.rvld[i] && buf_ready[i];
         n.rvld[i] = rd_en[i] || (s.rvld[i] && !buf_ready[i]);
         depth = (s.wa[i] >= s.ra[i]) ? s.wa[i] - s.ra[i] : s.wa[i] + `DEPTH_WRAP - s.ra[i];
         n.ovf[i] = s.run[i] && link_enable[i] && (depth > `DEPTH_MAX);

         p = s.pm[i];
         st_old = p.st;
         w = fifo_rd[i];
         if (w.frame) begin
            p.col = `COL_LAST;
            p.row = `ROW_LAST;
         end else if (p.col == `COL_LAST) begin
            p.col = 11'h000;
            p.row = (p.row == `ROW_LAST) ? 4'h0 : p.row + 4'h1;
         end else begin
            p.col = p.col + 11'h001;
         end
         if (p.row == `H_ROW && p.col == 11'h000) begin
            p.h1 = w.data;
         end
         if (p.row == `K_ROW && p.col == `K1_COL) begin
            p.k1 = w.data;
         end
         if (p.row == `K_ROW && p.col == `K2_COL) begin
            p.k2 = w.data;
         end
         if (p.row == `H_ROW && p.col == `H2_COL) begin
            hp = {p.h1, w.data};
            p.ss = p.h1[3:2];
            if (hp == `AIS_PTR) begin
               cls = cls_ais;
            end else if (nib_ok(hp[15:12], `NDF_CONCATENATION_POINTER_STATE) && hp[9:0] == `CONCATENATION_POINTER_STATE_VAL) begin
               cls = cls_concatenation_pointer_state;
            end else if ((nib_ok(hp[15:12], `NDF_NORMAL_POINTER_STATE) || nib_ok(hp[15:12], `NDF_CONCATENATION_POINTER_STATE)) && hp[9:0] <= `PTR_MAX) begin
               cls = cls_normal_pointer_state;
            end
            incd = p.st != ais_pointer_state && nib_ok(hp[15:12], `NDF_NORMAL_POINTER_STATE)
                   && ones10(~(hp[9:0] ^ p.off ^ `INC_MASK)) >= `VOTE_MIN;
            decd = p.st != ais_pointer_state && nib_ok(hp[15:12], `NDF_NORMAL_POINTER_STATE)
                   && ones10(~(hp[9:0] ^ p.off ^ `DEC_MASK)) >= `VOTE_MIN;
            if (incd || decd) begin
               // Passed on at the next F1 or E2 latch slot, however close to the last one
               p.off = off_step(p.off, incd);
               p.inc_req = p.inc_req || incd;
               p.dec_req = p.dec_req || decd;
               cls = cls_normal_pointer_state;
            end else begin
               case (cls)
                  cls_normal_pointer_state: begin
                     if (p.cls_prev == cls_normal_pointer_state || (p.st == ais_pointer_state && p.cls_prev == cls_concatenation_pointer_state)) begin
                        p.st = normal_pointer_state;
                        // A lone differing pointer passes only right after an increment or decrement
                        if (hp[9:0] != p.off && p.val_prev != p.off) begin
                           p.off = hp[9:0];
                        end
                     end
                  end
                  cls_concatenation_pointer_state: begin
                     if (p.cls_prev == cls_concatenation_pointer_state || (p.st == ais_pointer_state && p.cls_prev == cls_normal_pointer_state)) begin
                        p.st = concatenation_pointer_state;
                     end
                  end
                  cls_ais: begin
                     if (p.cls_prev == cls_ais) begin
                        p.st = ais_pointer_state;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            p.cls_prev = cls;
            p.val_prev = hp[9:0];
         end
         // Link 0 carries the chain head; others in a chain follow it
         if (p.st == concatenation_pointer_state && i != 0) begin
            p.off = s.pm[0].off;
         end
         if (st_old == ais_pointer_state && p.st != ais_pointer_state) begin
            p.ndf_flag = 1'b1;
         end
         if (p.st == ais_pointer_state) begin
            p.ais_out = 1'b1;
         end
         pay1 = p.col >= `TOH_COLS && (p.col % `STS_N) == 11'h000;
         if (pay1) begin
            idx = (p.row == `H_ROW && p.col == `TOH_COLS) ? 10'h000 : p.spe;
            p.spe = (idx == `PTR_MAX) ? 10'h000 : idx + 10'h001;
            if (idx == p.off) begin
               if (p.st != ais_pointer_state) begin
                  p.ais_out = 1'b0;
               end
               if (p.off != p.goff && !p.inc_req && !p.dec_req) begin
                  p.goff = p.off;
                  p.ndf_flag = 1'b1;
               end
            end
         end
         buf_in[i].data = (p.ais_out && (p.col >= `TOH_COLS || p.row == `H_ROW)) ? `AIS_BYTE : w.data;
         buf_in[i].frame = w.frame;
         buf_in[i].new_data_flag_indication = p.ndf_flag;
         buf_in[i].inc = p.inc_flag;
         buf_in[i].dec = p.dec_flag;
         p.ndf_flag = 1'b0;
         p.inc_flag = 1'b0;
         p.dec_flag = 1'b0;
         if (p.row == `H_ROW && p.col < `TOH_COLS) begin
            cf1 = s.srow == `F1_ROW && s.scol >= `LATCH_COL && s.scol < `TOH_COLS;
            ce2 = s.srow == `E2_ROW && s.scol >= `LATCH_COL && s.scol < `TOH_COLS;
            if (!p.slot_set) begin
               p.slot_set = 1'b1;
               p.slot_e2 = cf1;
            end else if (p.slot_e2 ? ce2 : cf1) begin
               p.slot_e2 = !p.slot_e2;
            end
         end
         if (!acc[i]) begin
            // An idle reader waits one byte ahead of A1 at address 0
            p = s.pm[i];
            p.col = s.run[i] ? p.col : `COL_LAST;
            p.row = s.run[i] ? p.row : `ROW_LAST;
         end
         // Latching away from the H bytes keeps H1 to H3 steady
         if (s.srow == (p.slot_e2 ? `E2_ROW : `F1_ROW) && s.scol == `LATCH_COL) begin
            if (p.inc_req) begin
               p.goff = off_step(p.goff, 1'b1);
               p.inc_flag = 1'b1;
               p.inc_req = 1'b0;
            end
            if (p.dec_req) begin
               p.goff = off_step(p.goff, 1'b0);
               p.dec_flag = 1'b1;
               p.dec_req = 1'b0;
            end
         end
         n.pm[i] = p;
         // Resync stops reads and rearms sync of this link only; its FIFO and buffer words are kept
         if (resync[i]) begin
            n.run[i] = 1'b0;
            n.rvld[i] = 1'b0;
            n.armed[i] = 1'b1;
            n.seen[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.armed <= 4'hF;
         s.scol <= `COL_LAST;
         s.srow <= `ROW_LAST;
      end else begin
         s <= n;
      end
   end

   assign align_err = s.err;
   assign align_ovf = s.ovf;
   generate
      for (g = 0; g < `LINKS; g++) begin : g_stat
         assign ptr_state[g] = s.pm[g].st;
         assign k1_byte[g]   = s.pm[g].k1;
         assign k2_byte[g]   = s.pm[g].k2;
         assign ss_bits[g]   = s.pm[g].ss;
      end
   endgenerate
endmodule // sts12_rx_align_pointer_mover
`default_nettype wire

// File: verif/link_src_model.sv
/*
 Upstream framer model: four byte links with frame pulses, one frame
 of 9720 bytes each. Assumes the bench pulses start after reset.
*/
`timescale 1ns/10ps
`default_nettype none
module link_src_model (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Control
   input  wire logic            start,
   input  wire logic [3:0][4:0] skew,
   input  wire logic            ais,
   // Links
   output var  logic [3:0][7:0] lk_data,
   output var  logic [3:0]      lk_fp
);
   int         pos [4];
   logic [3:0] run  = 4'h0;
   logic [7:0] tick = 8'h00;

   // Fixed pointer, never adjusted, so no rate limit is ever approached
   function automatic logic [7:0] byte_at(int p);
      int r;
      int c;
      r = p / 1080;
      c = p % 1080;
      if (r == 0 && c < 12) return 8'hF6;
      if (r == 0 && c < 24) return 8'h28;
      if (r == 3 && c == 0) return ais ? 8'hFF : 8'h68;
      if (r == 3 && c == 12) return ais ? 8'hFF : 8'h00;
      if (r == 4 && c == 12) return 8'hA5;
      if (r == 4 && c == 24) return 8'h3C;
      return 8'h00;
   endfunction

   always @(negedge clk or negedge rst_n) begin
      tick <= tick + 8'h01;
      for (int i = 0; i < 4; i++) begin
         if (!rst_n)
            run[i] <= 1'b0;
         else if (start) begin
            run[i] <= 1'b1;
            pos[i] <= 9718 - int'(skew[i]);
         end else
            pos[i] <= (pos[i] == 9719) ? 0 : pos[i] + 1;
      end
   end

   // Idle links toggle so a stale byte never looks valid
   always_comb
      for (int i = 0; i < 4; i++) begin
         lk_fp[i]   = run[i] && pos[i] == 9718;
         lk_data[i] = run[i] ? byte_at(pos[i]) : tick;
      end
endmodule // link_src_model
`default_nettype wire

// File: verif/sts12_rx_align_pointer_mover_sva.sv
/*
 Port checker of the receive path. Assumes it is bound to the top module.
*/
`timescale 1ns/10ps
`default_nettype none
module sts12_rx_sva
   import rx_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic [3:0][7:0]  lk_data,
   input wire logic [3:0]       lk_fp,
   input wire logic             sys_fp,
   input wire logic [3:0]       link_enable,
   input wire logic [3:0]       resync,
   input wire logic [3:0]       out_valid,
   input wire logic [3:0]       out_ready,
   input wire out_word_t [3:0]  out_data,
   input wire logic             align_err,
   input wire logic [3:0]       align_ovf,
   input wire ptr_state_t [3:0] ptr_state,
   input wire logic [3:0][7:0]  k1_byte,
   input wire logic [3:0][7:0]  k2_byte,
   input wire logic [3:0][1:0]  ss_bits
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence fp_all_s;
      link_enable == 4'hF && lk_fp == 4'hF && out_valid == 4'h0;
   endsequence
   sequence stall8_s;
      (out_valid[0] && !out_ready[0]) [*8];
   endsequence
   hold_stall_a: assert property (out_valid[0] && !out_ready[0] |=> out_valid[0] && $stable(out_data[0]))
      else $error("word changed under stall");
   aligned_start_a: assert property (fp_all_s |-> ##13 out_valid == 4'h0 ##1 out_valid == 4'hF)
      else $error("aligned read start off");
   same_start_a: assert property ($rose(out_valid[0]) && link_enable[1] |-> out_valid[1])
      else $error("links started apart");
   err_pulse_a: assert property (align_err |-> out_valid == 4'h0 ##1 !align_err)
      else $error("bad alignment error pulse");
   dis_quiet_a: assert property ((align_ovf & ~link_enable) == 4'h0)
      else $error("disabled link flagged");
   ovf_stall_a: assert property (stall8_s |-> ##[0:4] align_ovf[0])
      else $error("no overflow after stall");
   state_calm_a: assert property ($changed(ptr_state[0]) |=> $stable(ptr_state[0]) [*8])
      else $error("pointer state chatter");
   incdec_excl_a: assert property (out_valid[0] |-> !(out_data[0].inc && out_data[0].dec))
      else $error("increment and decrement together");
endmodule // sts12_rx_sva
bind sts12_rx_align_pointer_mover sts12_rx_sva chk_u (.clk, .rst_n, .lk_data, .lk_fp, .sys_fp, .link_enable,
   .resync, .out_valid, .out_ready, .out_data, .align_err, .align_ovf, .ptr_state, .k1_byte, .k2_byte, .ss_bits);
`default_nettype wire

// File: verif/sts12_rx_align_pointer_mover_tb_top.sv
/*
 Self-checking bench of the receive path with the link source model.
 Assumes a 10 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module sts12_rx_align_pointer_mover_tb_top
   import rx_pkg::*;
;
   localparam int LIMIT = 60000;
   logic             clk = 1'b0, rst_n = 1'b0, sys_fp = 1'b0, start = 1'b0, ais = 1'b0, align_err;
   logic [3:0]       lk_fp, link_enable = 4'hF, resync = 4'h0, out_valid, out_ready = 4'hF, align_ovf;
   logic [3:0][7:0]  lk_data, k1_byte, k2_byte;
   logic [3:0][4:0]  skew = '0;
   logic [3:0][1:0]  ss_bits;
   out_word_t [3:0]  out_data;
   ptr_state_t [3:0] ptr_state;
   int               err_total = 0, total_checks = 0, cyc = 0, cnt_ff = 0;
   logic             ndf_seen = 1'b0;

   link_src_model src_u (.clk, .rst_n, .start, .skew, .ais, .lk_data, .lk_fp);
   sts12_rx_align_pointer_mover dut_u (.clk, .rst_n, .lk_data, .lk_fp, .sys_fp, .link_enable, .resync,
      .out_valid, .out_ready, .out_data, .align_err, .align_ovf, .ptr_state, .k1_byte, .k2_byte, .ss_bits);

   always #50 clk = ~clk;
   always @(negedge clk) sys_fp <= (cyc % 9720) == 5;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (out_valid[0] && out_ready[0] && out_data[0].data === 8'hFF) cnt_ff <= cnt_ff + 1;
      if (out_valid[0] && out_ready[0] && out_data[0].new_data_flag_indication === 1'b1) ndf_seen <= 1'b1;
      if (cyc == LIMIT) begin
         err_total++;
         end_sim();
      end
   end

   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic do_reset(logic [3:0] en);
      @(negedge clk);
      rst_n = 1'b0;
      link_enable = en;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic go(logic [3:0][4:0] sk);
      skew <= sk;
      start <= 1'b1;
      @(negedge clk);
      start <= 1'b0;
   endtask
   task automatic next_fp();
      @(posedge clk);
      while (!lk_fp[0]) @(posedge clk);
   endtask
   // Sits on the frame pulse edge of link 0; valid is first sampled high at edge k
   task automatic expect_start(int k, logic [3:0] lo, logic [3:0] hi);
      next_fp();
      repeat (k - 2) @(posedge clk);
      @(negedge clk);
      chk("valid before start", out_valid, lo);
      @(negedge clk);
      chk("valid at start", out_valid, hi);
      chk("first word", out_data[0].data, 8'hF6);
   endtask
   task automatic t_aligned();
      do_reset(4'hF);
      go('0);
      expect_start(14, 4'h0, 4'hF);
   endtask
   task automatic t_ptr();
      cnt_ff = 0;
      next_fp();
      @(negedge clk);
      chk("k1", k1_byte, {4{8'hA5}});
      chk("k2", k2_byte, {4{8'h3C}});
      chk("ss", ss_bits, 8'hAA);
      chk("no fill", cnt_ff, 0);
      ais = 1'b1;
      next_fp();
      repeat (4500) @(posedge clk);
      @(negedge clk);
      chk("state ais", ptr_state, {4{ais_pointer_state}});
      chk("fill", cnt_ff > 500, 1);
      ais = 1'b0;
      ndf_seen = 1'b0;
      repeat (2) next_fp();
      repeat (4500) @(posedge clk);
      @(negedge clk);
      chk("state normal", ptr_state, {4{normal_pointer_state}});
      chk("new data flag", ndf_seen, 1);
   endtask
   // Untouched links sit at a depth of ten; a longer stall would wrap the depth
   task automatic t_stall();
      out_ready = 4'hE;
      repeat (8) @(negedge clk);
      chk("ovf stalled", align_ovf[0], 1);
      chk("ovf steady", align_ovf[1], 0);
      out_ready = 4'hF;
   endtask
   task automatic t_resync();
      resync = 4'h1;
      @(negedge clk);
      resync = 4'h0;
      repeat (3) @(negedge clk);
      go('0);
      expect_start(14, 4'hE, 4'hF);
   endtask
   task automatic t_spread();
      do_reset(4'h7);
      go({5'd10, 5'd3, 5'd1, 5'd0});
      expect_start(16, 4'h0, 4'h7);
   endtask
   task automatic t_err();
      int n;
      n = 0;
      do_reset(4'h3);
      go({5'd0, 5'd0, 5'd20, 5'd0});
      // The late pulse opens a fresh window that fails 19 clocks on; stop before it
      repeat (30) begin
         @(negedge clk);
         n += int'(align_err);
      end
      chk("err pulses", n, 1);
      chk("no read", out_valid, 4'h0);
   endtask
   task automatic end_sim();
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      t_aligned();
      t_ptr();
      t_stall();
      t_resync();
      t_spread();
      t_err();
      end_sim();
   end
endmodule // sts12_rx_align_pointer_mover_tb_top
`default_nettype wire
